//--- rlti_indexer.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Frames numbered from 0 by frequency, time, type; index at most 255.
// - Superframe lengths from 25 ms to 750 ms inclusive are accepted.
// - Each new superframe counter is previous plus one, wrapping at 65536.
// - Superframes follow back to back, each of identical length.
// - Assignments up to one second ahead are stored and tracked.
// - Timeslots numbered from 0 by frequency then time; at most 2047.
// - A timeslot is one unit or several contiguous units on one band.
// - All timeslots of a frame use one unit type and symbol rate.
// - A frame lasts no longer than its superframe.
// - Each frame carries bursts of one transmission format class only.
// - A slot is named by sequence, superframe count, frame and timeslot.
// - Each applicable allocation message entry for us is extracted.
// - Merged general slots map to one burst configuration type.
// - Fixed control and logon slots are permanent, beside dynamic ones.
// - A burst starts at its nominal offset, leaving guard time.
module rlti_indexer
  import rlti_pkg::*;
#(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned SF_LEN_DEF = SF_MIN_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Superframe timing set by the burst time plan.
  input wire logic [CNT_W-1:0] sf_len_i,
  input wire logic sf_start_i,
  input wire logic [SEQ_W-1:0] superframe_sequence_id_i,
  input wire logic [SFC_W-1:0] sfc_start_i,
  // Allocation entries extracted from each dynamic_allocation_message.
  input wire logic alloc_valid_i,
  input wire logic alloc_for_us_i,
  input wire logic [SEQ_W-1:0] alloc_seq_i,
  input wire logic [SFC_W-1:0] alloc_sfc_i,
  input wire logic [FRM_W-1:0] alloc_frame_i,
  input wire logic [SLT_W-1:0] alloc_slot_i,
  input wire logic [1:0] alloc_kind_i,
  input wire logic [TYP_W-1:0] alloc_type_i,
  input wire logic [3:0] alloc_units_i,
  input wire logic [FRM_W-1:0] frame_count_i,
  input wire logic [SLT_W-1:0] slot_count_i,
  input wire logic [CNT_W-1:0] frame_len_i,
  // Permanent control_burst_slot and logon_burst_slot of the frame.
  input wire logic [SLT_W-1:0] control_burst_slot_i,
  input wire logic [SLT_W-1:0] logon_burst_slot_i,
  // Current slot position and nominal burst placement.
  input wire logic [FRM_W-1:0] cur_frame_i,
  input wire logic [SLT_W-1:0] cur_slot_i,
  input wire logic slot_tick_i,
  input wire logic [CNT_W-1:0] offset_i,
  input wire logic [CNT_W-1:0] burst_len_i,
  output logic [SFC_W-1:0] sfc_o,
  output logic sf_boundary_o,
  output logic sf_len_ok_o,
  output logic plan_ok_o,
  output logic alloc_taken_o,
  output logic alloc_refused_o,
  output logic slot_hit_o,
  output logic [1:0] slot_kind_o,
  output logic [TYP_W-1:0] slot_type_o,
  output logic burst_o,
  output logic [$clog2(DEPTH+1)-1:0] used_o
);
  localparam int unsigned IW = $clog2(DEPTH);
  localparam int unsigned UW = $clog2(DEPTH+1);
  // Superframes per advance horizon at the shortest length, rounded up.
  localparam logic [SFC_W-1:0] ADV_SF =
    SFC_W'((ADV_MS * 1_000 + SF_MIN_US - 1) / SF_MIN_US);

  // Modulo distance, so the horizon holds across the counter wrap.
  function automatic logic sfc_ahead(input logic [SFC_W-1:0] a,
                                     input logic [SFC_W-1:0] b);
    logic [SFC_W-1:0] d;
    d = a - b;
    sfc_ahead = (d <= ADV_SF);
  endfunction

  logic [CNT_W-1:0] len_q;
  logic [CNT_W-1:0] tmr_q;
  logic [SFC_W-1:0] sfc_q;
  logic [SEQ_W-1:0] seq_q;
  logic run_q;
  logic wrap;
  logic len_ok;

  logic [DEPTH-1:0] vld_q;
  logic [SFC_W-1:0] e_sfc_q [DEPTH];
  logic [FRM_W-1:0] e_frm_q [DEPTH];
  logic [SLT_W-1:0] e_slt_q [DEPTH];
  logic [1:0] e_kind_q [DEPTH];
  logic [TYP_W-1:0] e_typ_q [DEPTH];

  // A length outside the window leaves the running sequence untouched.
  // length window.
  assign len_ok = (sf_len_i >= CNT_W'(SF_MIN_CYC)) &&
                  (sf_len_i <= CNT_W'(SF_MAX_CYC));
  assign wrap = run_q && (tmr_q == len_q - 1'b1);

  // A new sequence restarts the timer, since the old phase means nothing.
  // back to back.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      len_q <= CNT_W'(SF_LEN_DEF);
      tmr_q <= CNT_ZERO;
      run_q <= 1'b0;
      seq_q <= '0;
    end else if (sf_start_i && len_ok) begin
      len_q <= sf_len_i;
      tmr_q <= CNT_ZERO;
      run_q <= 1'b1;
      seq_q <= superframe_sequence_id_i;
    end else if (wrap) begin
      tmr_q <= CNT_ZERO;
    end else if (run_q) begin
      tmr_q <= tmr_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sfc_q <= SFC_ZERO;
    end else if (sf_start_i && len_ok) begin
      sfc_q <= sfc_start_i;
    end else if (wrap) begin
      sfc_q <= sfc_q + 1'b1;
    end
  end

  // Entry lookup against the current position.
  logic [DEPTH-1:0] hit;
  logic [DEPTH-1:0] stale;
  logic [IW-1:0] hit_idx;
  logic [IW-1:0] free_idx;
  logic any_free;
  logic any_hit;
  logic [UW-1:0] used;
  logic fixed_c;
  logic fixed_l;

  // Release falls on the last cycle of the superframe, which frees the
  // entry before grants for the next superframe arrive.
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      assign hit[g] = vld_q[g] && e_sfc_q[g] == sfc_q &&
                      e_frm_q[g] == cur_frame_i && e_slt_q[g] == cur_slot_i;
      assign stale[g] = vld_q[g] && wrap && e_sfc_q[g] == sfc_q;
    end
  endgenerate

  // The lowest matching index wins; the controller never doubles a slot.
  always_comb begin
    hit_idx = '0;
    free_idx = '0;
    any_free = 1'b0;
    any_hit = 1'b0;
    used = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (!vld_q[i]) begin
        free_idx = IW'(i);
        any_free = 1'b1;
      end
      if (hit[i]) begin
        hit_idx = IW'(i);
        any_hit = 1'b1;
      end
    end
    for (int i = 0; i < DEPTH; i++) begin
      used = used + UW'(vld_q[i]);
    end
  end

  // Plan limits are reported, not enforced; the plan source owns them.
  // bounds of the plan.
  logic plan_ok;
  assign plan_ok = frame_count_i <= FRM_MAX && slot_count_i <= SLT_MAX &&
                   frame_len_i <= len_q && frame_len_i != CNT_ZERO;

  // index range and contiguous units of one type.
  logic fits;
  assign fits = alloc_frame_i < frame_count_i &&
                alloc_slot_i < slot_count_i && alloc_units_i != 4'h0 &&
                {1'b0, alloc_slot_i} + {8'h00, alloc_units_i} <=
                {1'b0, slot_count_i};

  logic acc;
  logic in_range;
  assign in_range = sfc_ahead(alloc_sfc_i, sfc_q);
  assign acc = alloc_valid_i && alloc_for_us_i && run_q &&
               alloc_seq_i == seq_q && in_range && any_free && fits;

  // A new sequence drops every entry but one accepted in that same cycle, since old counts refer elsewhere.
  // store entry.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vld_q <= '0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (stale[i] || (sf_start_i && len_ok)) begin
          vld_q[i] <= 1'b0;
        end
      end
      // A new entry wins over a release of the same slot position.
      if (acc) begin
        vld_q[free_idx] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (acc) begin
      e_sfc_q[free_idx] <= alloc_sfc_i;
      e_frm_q[free_idx] <= alloc_frame_i;
      e_slt_q[free_idx] <= alloc_slot_i;
      e_kind_q[free_idx] <= alloc_kind_i;
      e_typ_q[free_idx] <= alloc_type_i;
    end
  end

  // Fixed slots match by slot number in every frame, which suits plans
  // that repeat them frame after frame.
  // permanent slots.
  assign fixed_c = run_q && cur_slot_i == control_burst_slot_i;
  assign fixed_l = run_q && cur_slot_i == logon_burst_slot_i;

  logic burst_w;
  logic go;
  assign go = slot_tick_i && (any_hit || fixed_c || fixed_l);

  // A start that lands while a burst is pending is dropped, so the plan
  // must give each burst room to end before the next slot tick.
  // timed burst.
  rlti_slot_timer #(
    .W(CNT_W)
  ) u_timer (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(go),
    .offset_i(offset_i),
    .burst_len_i(burst_len_i),
    .burst_o(burst_w),
    .busy_o()
  );

  // Outputs are registered so the pins carry no decode glitch.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sfc_o <= SFC_ZERO;
      sf_boundary_o <= 1'b0;
      sf_len_ok_o <= 1'b0;
      plan_ok_o <= 1'b0;
    end else begin
      sfc_o <= sfc_q;
      sf_boundary_o <= wrap;
      sf_len_ok_o <= len_ok;
      plan_ok_o <= plan_ok;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alloc_taken_o <= 1'b0;
      alloc_refused_o <= 1'b0;
      used_o <= '0;
      burst_o <= 1'b0;
    end else begin
      alloc_taken_o <= acc;
      alloc_refused_o <= alloc_valid_i && alloc_for_us_i && !acc;
      used_o <= used;
      burst_o <= burst_w;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot_hit_o <= 1'b0;
      slot_kind_o <= RL_KIND_CTRL;
      slot_type_o <= '0;
    end else if (slot_tick_i) begin
      slot_hit_o <= any_hit || fixed_c || fixed_l;
      // A dynamic entry wins over the fixed slots when both match.
      if (any_hit) begin
        slot_kind_o <= e_kind_q[hit_idx];
        slot_type_o <= e_typ_q[hit_idx];
      end else if (fixed_c) begin
        slot_kind_o <= RL_KIND_CTRL;
        slot_type_o <= '0;
      end else begin
        slot_kind_o <= RL_KIND_LOGON;
        slot_type_o <= '0;
      end
    end
  end
endmodule
`default_nettype wire

//--- rlti_pkg.sv
package rlti_pkg;
  // Reference clock rate and superframe duration span.
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned SF_MIN_US = 25_000;
  localparam int unsigned SF_MAX_US = 750_000;
  localparam int unsigned SF_MIN_CYC = SF_MIN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SF_MAX_CYC = SF_MAX_US * (CLK_HZ / 1_000_000);
  // Advance horizon for assignments.
  localparam int unsigned ADV_MS = 1_000;
  // Index widths and limits.
  localparam int unsigned SFC_W = 16;
  localparam int unsigned FRM_W = 8;
  localparam int unsigned SLT_W = 11;
  localparam int unsigned SEQ_W = 8;
  localparam int unsigned TYP_W = 6;
  localparam int unsigned CNT_W = 32;
  localparam logic [FRM_W-1:0] FRM_MAX = 8'h00_FF;
  localparam logic [SLT_W-1:0] SLT_MAX = 11'h07_FF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [SFC_W-1:0] SFC_ZERO = 16'h0000;
  // Allocation kinds carried with each entry.
  typedef enum logic [1:0] {
    RL_KIND_CTRL = 2'b00,
    RL_KIND_RAND = 2'b01,
    RL_KIND_DED = 2'b10,
    RL_KIND_LOGON = 2'b11
  } rl_kind_t;
  typedef enum logic [1:0] {
    RL_ST_IDLE = 2'b00,
    RL_ST_WAIT = 2'b01,
    RL_ST_BURST = 2'b10
  } rl_state_t;
endpackage

//--- rlti_slot_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Places a burst at its nominal offset inside a slot of whole
// bandwidth-time units; the remainder of the slot stays idle as guard.
module rlti_slot_timer
  import rlti_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [W-1:0] offset_i,
  input wire logic [W-1:0] burst_len_i,
  output logic burst_o,
  output logic busy_o
);
  rl_state_t st_q;
  logic [W-1:0] cnt_q;
  logic [W-1:0] len_q;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= RL_ST_IDLE;
      cnt_q <= '0;
      len_q <= '0;
    end else begin
      unique case (st_q)
        RL_ST_IDLE: begin
          if (start_i) begin
            cnt_q <= offset_i;
            len_q <= burst_len_i;
            st_q <= RL_ST_WAIT;
          end
        end
        RL_ST_WAIT: begin
          if (cnt_q == '0) begin
            cnt_q <= len_q;
            st_q <= (len_q == '0) ? RL_ST_IDLE : RL_ST_BURST;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        RL_ST_BURST: begin
          if (cnt_q <= W'(1)) begin
            st_q <= RL_ST_IDLE;
          end
          cnt_q <= cnt_q - 1'b1;
        end
        default: st_q <= RL_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      burst_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      burst_o <= (st_q == RL_ST_WAIT && cnt_q == '0 && len_q != '0) ||
                 (st_q == RL_ST_BURST && cnt_q > W'(1));
      busy_o <= (st_q != RL_ST_IDLE) || start_i;
    end
  end
endmodule
`default_nettype wire

//--- rlti_indexer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rlti_indexer_chk
  import rlti_pkg::*;
#(
  parameter int unsigned DEPTH = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [CNT_W-1:0] sf_len_i,
  input wire logic sf_start_i,
  input wire logic alloc_valid_i,
  input wire logic alloc_for_us_i,
  input wire logic [FRM_W-1:0] alloc_frame_i,
  input wire logic [FRM_W-1:0] frame_count_i,
  input wire logic slot_tick_i,
  input wire logic [SFC_W-1:0] sfc_o,
  input wire logic sf_len_ok_o,
  input wire logic alloc_taken_o,
  input wire logic alloc_refused_o,
  input wire logic slot_hit_o,
  input wire logic burst_o,
  input wire logic [$clog2(DEPTH+1)-1:0] used_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  chk_take_cause: assert property (
    alloc_taken_o |-> $past(alloc_valid_i && alloc_for_us_i))
    else $error("take without request");
  chk_refuse_cause: assert property (
    alloc_refused_o |-> $past(alloc_valid_i) && !alloc_taken_o)
    else $error("refuse without request");
  chk_frame_range: assert property (
    alloc_taken_o |-> $past(alloc_frame_i) < $past(frame_count_i))
    else $error("frame out of range taken");
  chk_used_step: assert property (
    alloc_taken_o |=> used_o == $past(used_o) + 1'b1)
    else $error("entry count did not grow");
  chk_sfc_step: assert property (
    $changed(sfc_o) |-> sfc_o == $past(sfc_o) + 1'b1 || $past(sf_start_i)
      || $past(sf_start_i, 2))
    else $error("counter skipped");
  // Two edges of history keep the flag out of the reset shadow.
  chk_len_range: assert property (
    $past(rst_n_i, 2) |-> sf_len_ok_o == ($past(sf_len_i) >= SF_MIN_CYC
      && $past(sf_len_i) <= SF_MAX_CYC))
    else $error("length flag wrong");
  chk_hit_tick: assert property (
    $changed(slot_hit_o) |-> $past(slot_tick_i) || $past(sf_start_i))
    else $error("hit changed off tick");
  chk_burst_slot: assert property (
    $rose(burst_o) |-> slot_hit_o)
    else $error("burst outside hit slot");
  cover property (alloc_refused_o);
  cover property ($rose(burst_o));
  cover property ($changed(sfc_o));
endmodule
bind rlti_indexer rlti_indexer_chk #(.DEPTH(DEPTH)) u_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sf_len_i(sf_len_i),
  .sf_start_i(sf_start_i), .alloc_valid_i(alloc_valid_i),
  .alloc_for_us_i(alloc_for_us_i), .alloc_frame_i(alloc_frame_i),
  .frame_count_i(frame_count_i), .slot_tick_i(slot_tick_i), .sfc_o(sfc_o),
  .sf_len_ok_o(sf_len_ok_o), .alloc_taken_o(alloc_taken_o),
  .alloc_refused_o(alloc_refused_o), .slot_hit_o(slot_hit_o),
  .burst_o(burst_o), .used_o(used_o));
`default_nettype wire

//--- rlti_ncc_model.sv
`timescale 1ns/1ps
`default_nettype none
module rlti_ncc_model
  import rlti_pkg::*;
#(
  parameter logic [SEQ_W-1:0] SEQ = 8'h5A
) (
  input wire logic clk_i,
  output logic valid_o,
  output logic for_us_o,
  output logic [SEQ_W-1:0] seq_o,
  output logic [SFC_W-1:0] sfc_o,
  output logic [FRM_W-1:0] frame_o,
  output logic [SLT_W-1:0] slot_o,
  output logic [1:0] kind_o,
  output logic [TYP_W-1:0] type_o,
  output logic [3:0] units_o
);
  initial begin
    valid_o = 1'b0;
    {for_us_o, seq_o, sfc_o, frame_o, slot_o, kind_o, type_o, units_o} = '0;
  end
  // One grant per call, typed per kind, owned by one terminal.
  task grant(input logic us, input logic [SFC_W-1:0] sfc,
      input logic [FRM_W-1:0] frm, input logic [SLT_W-1:0] slt,
      input logic [1:0] kind, input logic [3:0] units);
    @(posedge clk_i);
    valid_o <= 1'b1;
    {for_us_o, seq_o, sfc_o, frame_o, slot_o, kind_o, units_o} <=
      {us, SEQ, sfc, frm, slt, kind, units};
    type_o <= 6'h10 + 6'(kind);
    @(posedge clk_i);
    valid_o <= 1'b0;
    // Released fields other than type_o flip so a stale value never passes for a grant.
    {for_us_o, seq_o, sfc_o, frame_o, slot_o, kind_o, units_o} <=
      ~{us, SEQ, sfc, frm, slt, kind, units};
  endtask
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import rlti_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sf_start_i = 1'b0;
  logic slot_tick_i = 1'b0;
  logic [CNT_W-1:0] sf_len_i = CNT_W'(SF_MIN_CYC);
  logic [CNT_W-1:0] frame_len_i = CNT_W'(SF_MIN_CYC);
  logic [CNT_W-1:0] offset_i = 32'h0000_0010;
  logic [CNT_W-1:0] burst_len_i = 32'h0000_0004;
  logic [SFC_W-1:0] sfc_start_i = 16'h0000;
  logic [SEQ_W-1:0] sfs_id = 8'h5A;
  logic [FRM_W-1:0] cur_frame_i = 8'h00;
  logic [SLT_W-1:0] cur_slot_i = 11'h000;
  logic a_vld, a_us, sf_ok, plan_ok, taken, refused, hit, burst, bnd;
  logic [SEQ_W-1:0] a_seq;
  logic [SFC_W-1:0] a_sfc, sfc;
  logic [FRM_W-1:0] a_frm;
  logic [SLT_W-1:0] a_slt;
  logic [1:0] a_kind, kind;
  logic [TYP_W-1:0] a_typ, typ;
  logic [3:0] a_units;
  logic [4:0] used;
  int err_total = 0;
  int comparisons = 0;
  int w;
  int h;
  always #2 ref_clk_i = ~ref_clk_i;
  rlti_ncc_model ncc (.clk_i(ref_clk_i), .valid_o(a_vld), .for_us_o(a_us),
    .seq_o(a_seq), .sfc_o(a_sfc), .frame_o(a_frm), .slot_o(a_slt),
    .kind_o(a_kind), .type_o(a_typ), .units_o(a_units));
  rlti_indexer uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .sf_len_i(sf_len_i), .sf_start_i(sf_start_i),
    .superframe_sequence_id_i(sfs_id), .sfc_start_i(sfc_start_i),
    .alloc_valid_i(a_vld), .alloc_for_us_i(a_us), .alloc_seq_i(a_seq),
    .alloc_sfc_i(a_sfc), .alloc_frame_i(a_frm), .alloc_slot_i(a_slt),
    .alloc_kind_i(a_kind), .alloc_type_i(a_typ), .alloc_units_i(a_units),
    .frame_count_i(8'h10), .slot_count_i(11'h040), .frame_len_i(frame_len_i),
    .control_burst_slot_i(11'h030), .logon_burst_slot_i(11'h031),
    .cur_frame_i(cur_frame_i), .cur_slot_i(cur_slot_i),
    .slot_tick_i(slot_tick_i), .offset_i(offset_i),
    .burst_len_i(burst_len_i), .sfc_o(sfc), .sf_boundary_o(bnd),
    .sf_len_ok_o(sf_ok), .plan_ok_o(plan_ok), .alloc_taken_o(taken),
    .alloc_refused_o(refused), .slot_hit_o(hit), .slot_kind_o(kind),
    .slot_type_o(typ), .burst_o(burst), .used_o(used));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task settle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task t_len();
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_i);
      sf_len_i <= (i < 2) ? CNT_W'(SF_MIN_CYC - 1 + i)
        : CNT_W'(SF_MAX_CYC - 2 + i);
      settle(2);
      check(sf_ok, (i == 1 || i == 2));
    end
  endtask
  task start_sf(input logic [SFC_W-1:0] s);
    @(posedge ref_clk_i);
    sf_len_i <= CNT_W'(SF_MAX_CYC);
    sfc_start_i <= s;
    sf_start_i <= 1'b1;
    @(posedge ref_clk_i);
    sf_start_i <= 1'b0;
    settle(2);
    check(sfc, s);
    check(used, 5'h00);
    check(bnd, 1'b0);
  endtask
  task t_plan();
    check(plan_ok, 1'b1);
    @(posedge ref_clk_i);
    frame_len_i <= CNT_W'(SF_MAX_CYC + 1);
    settle(2);
    check(plan_ok, 1'b0);
    @(posedge ref_clk_i);
    frame_len_i <= CNT_W'(SF_MIN_CYC);
  endtask
  task ask(input logic us, input logic [SFC_W-1:0] s,
      input logic [FRM_W-1:0] f, input logic [SLT_W-1:0] t,
      input logic [3:0] u, input logic exp);
    ncc.grant(us, s, f, t, RL_KIND_DED, u);
    #1;
    check(taken, exp);
  endtask
  task t_alloc();
    ask(1'b1, 16'h0000, 8'h0F, 11'h03C, 4'h4, 1'b1);
    ask(1'b1, 16'h0000, 8'h10, 11'h000, 4'h1, 1'b0);
    check(refused, 1'b1);
    ask(1'b1, 16'h0000, 8'h00, 11'h03D, 4'h4, 1'b0);
    ask(1'b1, 16'h0000, 8'h00, 11'h040, 4'h1, 1'b0);
    ask(1'b1, 16'h0028, 8'h00, 11'h000, 4'h1, 1'b0);
    ask(1'b1, 16'h0027, 8'h00, 11'h000, 4'h1, 1'b1);
    ask(1'b0, 16'h0000, 8'h01, 11'h000, 4'h1, 1'b0);
    for (int k = 0; k < 4; k++) begin
      ncc.grant(1'b1, 16'hFFFF, 8'h02, 11'(2 * k), 2'(k), 4'h1);
      #1;
      check(taken, 1'b1);
    end
    settle(1);
    check(used, 5'h06);
  endtask
  task tick(input logic [FRM_W-1:0] f, input logic [SLT_W-1:0] t,
      input logic exp, input logic [1:0] k);
    // A long gap lets the previous burst finish before the next slot.
    repeat (24) @(posedge ref_clk_i);
    cur_frame_i <= f;
    cur_slot_i <= t;
    slot_tick_i <= 1'b1;
    @(posedge ref_clk_i);
    slot_tick_i <= 1'b0;
    #1;
    check(hit, exp);
    if (exp) begin
      check(kind, k);
    end
  endtask
  task t_hit();
    for (int k = 0; k < 4; k++) begin
      tick(8'h02, 11'(2 * k), 1'b1, 2'(k));
      check(typ, 6'h10 + 6'(k));
    end
    tick(8'h07, 11'h030, 1'b1, RL_KIND_CTRL);
    tick(8'h07, 11'h031, 1'b1, RL_KIND_LOGON);
    tick(8'h02, 11'h020, 1'b0, RL_KIND_CTRL);
  endtask
  task t_burst();
    @(posedge ref_clk_i);
    offset_i <= 32'h0000_0008;
    burst_len_i <= 32'h0000_0006;
    tick(8'h02, 11'h004, 1'b1, RL_KIND_DED);
    w = 0;
    h = 0;
    for (int i = 0; i < 30; i++) begin
      settle(1);
      if (burst) h++;
      else if (h == 0) w++;
    end
    check(w >= 6 && w <= 10, 1'b1);
    check(h >= 4 && h <= 6, 1'b1);
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_len();
    start_sf(16'hFFFF);
    t_plan();
    t_alloc();
    t_hit();
    t_burst();
    @(posedge ref_clk_i);
    sfs_id <= 8'h33;
    start_sf(16'h0000);
    ask(1'b1, 16'h0001, 8'h00, 11'h000, 4'h1, 1'b0);
    results();
  end
  initial begin
    #40000;
    err_total++;
    results();
  end
endmodule
`default_nettype wire
